/* arc_pkg.sv */
// arc_pkg: register map, field positions, reset values and dividers
// for the auto-reload capture timer; assumes a 32-bit apb slave.
package arc_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] ARC_ADDR_CTRL = 8'h00; // timer_control_reg
  localparam logic [7:0] ARC_ADDR_RLL = 8'h04; // reload_low_byte
  localparam logic [7:0] ARC_ADDR_RLH = 8'h08; // reload_high_byte
  localparam logic [7:0] ARC_ADDR_CNTL = 8'h0C; // count_low_byte
  localparam logic [7:0] ARC_ADDR_CNTH = 8'h10; // count_high_byte
  localparam logic [7:0] ARC_ADDR_CLOCK_CONTROL_REG = 8'h14; // clock_control_reg
  localparam logic [7:0] ARC_ADDR_EIE = 8'h18; // ext_irq_enable_reg
  localparam logic [7:0] ARC_ADDR_STAT = 8'h1C; // sticky event status
  localparam logic [7:0] ARC_ADDR_MASK = 8'h20; // event mask

  // timer_control_reg fields
  localparam int ARC_CTRL_HOF = 7; // high_overflow_flag
  localparam int ARC_CTRL_LOF = 6; // low_overflow_flag
  localparam int ARC_CTRL_LBIE = 5; // low_byte_irq_en
  localparam int ARC_CTRL_CAPEN = 4; // capture_enable
  localparam int ARC_CTRL_SPLIT = 3; // split_mode_sel
  localparam int ARC_CTRL_RUN = 2; // run_control
  localparam int ARC_CTRL_XCLK = 0; // ext_clock_select, two bits
  localparam int ARC_XCLK_CAPSEL = 1; // bit of ext_clock_select picking trigger

  // clock_control_reg and ext_irq_enable_reg fields
  localparam int ARC_CK_LOW = 0; // low_byte_clk_sel
  localparam int ARC_CK_HIGH = 1; // high_byte_clk_sel
  localparam int ARC_EIE_TMR = 7; // timer interrupt enable

  // event status bits
  localparam int ARC_EV_HOF = 0;
  localparam int ARC_EV_LOF = 1;
  localparam int ARC_EV_CAP = 2;
  localparam int ARC_EV_W = 3;

  // external clock select encodings
  localparam logic [1:0] ARC_XCLK_DIV12A = 2'h0;
  localparam logic [1:0] ARC_XCLK_EXT8 = 2'h1;
  localparam logic [1:0] ARC_XCLK_DIV12B = 2'h2;
  localparam logic [1:0] ARC_XCLK_CMP1 = 2'h3;

  // dividers: last count value of each prescaler
  localparam logic [3:0] ARC_DIV12_LAST = 4'hB;
  localparam logic [2:0] ARC_DIV8_LAST = 3'h7;

  localparam logic [7:0] ARC_BYTE_RST = 8'h00;
  localparam logic [7:0] ARC_BYTE_MAX = 8'hFF;
  localparam logic [7:0] ARC_BYTE_ONE = 8'h01;
  localparam logic [31:0] ARC_RDATA_RST = 32'h0000_0000;

endpackage

/* arc_sync_edge.sv */
// arc_sync_edge: two-flop synchroniser with rising-edge detect.
// assumes din may change at any time relative to clk.
`timescale 1ns/10ps
module arc_sync_edge (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic din,
  output logic rise
);
  logic meta_reg; // first stage, read only by the second
  logic sync_reg; // settled level
  logic prev_reg; // level one cycle ago, for the edge

  // synchroniser chain; the edge is taken after the second stage only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // one-cycle pulse on a settled rising edge
  assign rise = sync_reg & ~prev_reg;
endmodule

/* arc_timer.sv */
// arc_timer: 16-bit / dual 8-bit auto-reload timer with capture, apb slave.
// assumes comparator and oscillator inputs are asynchronous; all else on CLK.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// - two count bytes, split bit picks mode
// - four clock sources, slow ones synchronised
// - 16-bit wrap outside capture mode reloads pair, sets high flag
// - timer enable requests interrupt on overflow
// - low-byte enable adds low wrap interrupts
// - split bytes reload from own reload byte
// - split: run gates high only, low free
// - per-byte clock select and external select decode
// - each byte wrap sets its own flag, bar the high flag on a capture-mode 16-bit wrap
// - split interrupts: high, or either with enable
// - flags cleared only by software writes
// - capture on comparator edge or ext/8
// - capture copies count to reload, sets flag
// - capture enable lives at control bit four
module arc_timer (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COMP1,
  input wire logic EXT_OSC,
  output logic TIMER_IRQ,
  output logic IRQ
);
  import arc_pkg::*;

  logic [7:0] ctrl_reg; // timer_control_reg
  logic [7:0] rll_reg; // reload_low_byte
  logic [7:0] rlh_reg; // reload_high_byte
  logic [7:0] cntl_reg; // count_low_byte
  logic [7:0] cnth_reg; // count_high_byte
  logic [1:0] clock_control_reg_reg; // clock_control_reg, two used bits
  logic eie_reg; // timer interrupt enable
  logic [ARC_EV_W-1:0] stat_reg; // sticky events
  logic [ARC_EV_W-1:0] mask_reg; // event mask
  logic [31:0] prdata_reg; // read data, loaded in setup phase
  logic [3:0] div12_reg; // system clock prescaler
  logic [2:0] div8_reg; // external edge prescaler

  logic [7:0] cntl_next;
  logic [7:0] cnth_next;
  logic lo_ovf; // low byte wrap this cycle
  logic hi_ovf; // high byte / 16-bit wrap this cycle
  logic cap_evt; // capture trigger this cycle
  logic tick_sys12; // system clock / 12
  logic tick_ext8; // external clock / 8
  logic cmp_rise; // synchronised comparator edge
  logic ext_rise; // synchronised oscillator edge
  logic tick_lo; // selected low byte tick
  logic tick_hi; // selected high byte tick

  // apb qualifiers; nothing is taken while CE is low
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  assign setup_ph = CE & PSEL & ~PENABLE;
  assign access_ph = CE & PSEL & PENABLE;
  assign wr_acc = access_ph & PWRITE;

  // control field views
  logic split_m;
  logic run_m;
  logic cap_m;
  logic [1:0] xclk_m;
  assign split_m = ctrl_reg[ARC_CTRL_SPLIT];
  assign run_m = ctrl_reg[ARC_CTRL_RUN];
  assign cap_m = ctrl_reg[ARC_CTRL_CAPEN];
  assign xclk_m = ctrl_reg[ARC_CTRL_XCLK +: 2];

  // address hit, used by every write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // mapped address check for the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, ARC_ADDR_CTRL) | hit(a, ARC_ADDR_RLL) | hit(a, ARC_ADDR_RLH) |
      hit(a, ARC_ADDR_CNTL) | hit(a, ARC_ADDR_CNTH) | hit(a, ARC_ADDR_CLOCK_CONTROL_REG) |
      hit(a, ARC_ADDR_EIE) | hit(a, ARC_ADDR_STAT) | hit(a, ARC_ADDR_MASK);
  endfunction

  // per-byte source decode: system_clock when sel, else external select
  function automatic logic src_tick(input logic sel, input logic [1:0] xs,
                                    input logic t12, input logic t8, input logic tc);
    if (sel) begin
      src_tick = 1'b1; // every system clock
    end else begin
      case (xs)
        ARC_XCLK_DIV12A: src_tick = t12;
        ARC_XCLK_EXT8: src_tick = t8;
        ARC_XCLK_DIV12B: src_tick = t12;
        ARC_XCLK_CMP1: src_tick = tc;
        default: src_tick = 1'b0;
      endcase
    end
  endfunction

  // slow sources cross into CLK before use
  arc_sync_edge u_cmp_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .din(COMP1),
    .rise(cmp_rise)
  );
  arc_sync_edge u_ext_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .din(EXT_OSC),
    .rise(ext_rise)
  );

  // prescalers for /12 and external /8
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div12_reg <= '0;
      div8_reg <= '0;
    end else if (CE) begin
      div12_reg <= (div12_reg == ARC_DIV12_LAST) ? '0 : div12_reg + 4'h1;
      if (ext_rise) begin
        div8_reg <= div8_reg + 3'h1; // wraps naturally at eight
      end
    end
  end
  assign tick_sys12 = (div12_reg == ARC_DIV12_LAST);
  assign tick_ext8 = ext_rise & (div8_reg == ARC_DIV8_LAST);

  // source selection per byte
  assign tick_lo = src_tick(clock_control_reg_reg[ARC_CK_LOW], xclk_m, tick_sys12, tick_ext8, cmp_rise);
  assign tick_hi = src_tick(clock_control_reg_reg[ARC_CK_HIGH], xclk_m, tick_sys12, tick_ext8, cmp_rise);

  // capture trigger: comparator edge when select bit is zero
  assign cap_evt = cap_m & (xclk_m[ARC_XCLK_CAPSEL] ? tick_ext8 : cmp_rise);

  // next count and wrap events
  always_comb begin
    cntl_next = cntl_reg;
    cnth_next = cnth_reg;
    lo_ovf = 1'b0;
    hi_ovf = 1'b0;
    if (split_m) begin
      // low byte always runs in split mode
      if (tick_lo) begin
        lo_ovf = (cntl_reg == ARC_BYTE_MAX);
        cntl_next = lo_ovf ? rll_reg : cntl_reg + ARC_BYTE_ONE;
      end
      if (run_m && tick_hi) begin
        hi_ovf = (cnth_reg == ARC_BYTE_MAX);
        cnth_next = hi_ovf ? rlh_reg : cnth_reg + ARC_BYTE_ONE;
      end
    end else if (run_m && tick_lo) begin
      lo_ovf = (cntl_reg == ARC_BYTE_MAX);
      if (lo_ovf && cnth_reg == ARC_BYTE_MAX) begin
        // full wrap: capture mode free-runs, otherwise reload the pair
        hi_ovf = ~cap_m;
        {cnth_next, cntl_next} = cap_m ? {ARC_BYTE_RST, ARC_BYTE_RST} : {rlh_reg, rll_reg};
      end else begin
        {cnth_next, cntl_next} = {cnth_reg, cntl_reg} + {ARC_BYTE_RST, ARC_BYTE_ONE};
      end
    end
  end

  // count bytes: a software write wins over counting
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cntl_reg <= ARC_BYTE_RST;
      cnth_reg <= ARC_BYTE_RST;
    end else if (CE) begin
      cntl_reg <= (wr_acc && hit(PADDR, ARC_ADDR_CNTL)) ? PWDATA[7:0] : cntl_next;
      cnth_reg <= (wr_acc && hit(PADDR, ARC_ADDR_CNTH)) ? PWDATA[7:0] : cnth_next;
    end
  end

  // reload bytes: capture wins over a software write in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rll_reg <= ARC_BYTE_RST;
      rlh_reg <= ARC_BYTE_RST;
    end else if (CE) begin
      if (cap_evt) begin
        {rlh_reg, rll_reg} <= {cnth_reg, cntl_reg};
      end else begin
        if (wr_acc && hit(PADDR, ARC_ADDR_RLL)) begin
          rll_reg <= PWDATA[7:0];
        end
        if (wr_acc && hit(PADDR, ARC_ADDR_RLH)) begin
          rlh_reg <= PWDATA[7:0];
        end
      end
    end
  end

  // control register; overflow flags set by hardware win over a write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= ARC_BYTE_RST;
    end else if (CE) begin
      if (wr_acc && hit(PADDR, ARC_ADDR_CTRL)) begin
        ctrl_reg <= PWDATA[7:0];
      end
      // flags never drop except by the write above
      if (hi_ovf || cap_evt) begin
        ctrl_reg[ARC_CTRL_HOF] <= 1'b1;
      end
      if (lo_ovf) begin
        ctrl_reg[ARC_CTRL_LOF] <= 1'b1;
      end
    end
  end

  // clock select, interrupt enable and mask
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clock_control_reg_reg <= '0;
      eie_reg <= 1'b0;
      mask_reg <= '0;
    end else if (CE) begin
      if (wr_acc && hit(PADDR, ARC_ADDR_CLOCK_CONTROL_REG)) begin
        clock_control_reg_reg <= PWDATA[1:0];
      end
      if (wr_acc && hit(PADDR, ARC_ADDR_EIE)) begin
        eie_reg <= PWDATA[ARC_EIE_TMR];
      end
      if (wr_acc && hit(PADDR, ARC_ADDR_MASK)) begin
        mask_reg <= PWDATA[ARC_EV_W-1:0];
      end
    end
  end

  // sticky events; a read clears only bits it returned, so new events survive
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stat_reg <= '0;
    end else if (CE) begin
      stat_reg <= (stat_reg & ~((access_ph && !PWRITE && hit(PADDR, ARC_ADDR_STAT)) ?
        prdata_reg[ARC_EV_W-1:0] : {ARC_EV_W{1'b0}})) | {cap_evt, lo_ovf, hi_ovf};
    end
  end

  // read data is latched in the setup phase so PRDATA comes from a flop
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_reg <= ARC_RDATA_RST;
    end else if (setup_ph) begin
      case (PADDR)
        ARC_ADDR_CTRL: prdata_reg <= {24'h00_0000, ctrl_reg};
        ARC_ADDR_RLL: prdata_reg <= {24'h00_0000, rll_reg};
        ARC_ADDR_RLH: prdata_reg <= {24'h00_0000, rlh_reg};
        ARC_ADDR_CNTL: prdata_reg <= {24'h00_0000, cntl_reg};
        ARC_ADDR_CNTH: prdata_reg <= {24'h00_0000, cnth_reg};
        ARC_ADDR_CLOCK_CONTROL_REG: prdata_reg <= {30'h0000_0000, clock_control_reg_reg};
        ARC_ADDR_EIE: prdata_reg <= {24'h00_0000, eie_reg, 7'h00};
        ARC_ADDR_STAT: prdata_reg <= {29'h0000_0000, stat_reg};
        ARC_ADDR_MASK: prdata_reg <= {29'h0000_0000, mask_reg};
        default: prdata_reg <= ARC_RDATA_RST; // unmapped reads as zero
      endcase
    end
  end

  // apb answer: zero wait states while enabled, error on unmapped address
  assign PRDATA = prdata_reg;
  assign PREADY = CE;
  assign PSLVERR = access_ph & ~mapped(PADDR);

  // timer interrupt request from the sticky overflow flags
  assign TIMER_IRQ = eie_reg & (ctrl_reg[ARC_CTRL_HOF] |
    (ctrl_reg[ARC_CTRL_LBIE] & ctrl_reg[ARC_CTRL_LOF]));
  // event interrupt: unmasked sticky bits
  assign IRQ = |(stat_reg & mask_reg);

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic cnt_wr;
  logic rl_wr;
  logic ctrl_wr;
  assign cnt_wr = wr_acc & (hit(PADDR, ARC_ADDR_CNTL) | hit(PADDR, ARC_ADDR_CNTH));
  assign rl_wr = wr_acc & (hit(PADDR, ARC_ADDR_RLL) | hit(PADDR, ARC_ADDR_RLH));
  assign ctrl_wr = wr_acc & hit(PADDR, ARC_ADDR_CTRL);

  wrap_reload_a: assert property (
    (CE && !split_m && !cap_m && run_m && tick_lo && {cnth_reg, cntl_reg} == 16'hFFFF &&
     !cnt_wr && !rl_wr && !ctrl_wr) |=> ({cnth_reg, cntl_reg} == $past({rlh_reg, rll_reg}))
     && ctrl_reg[ARC_CTRL_HOF]) else $error("16-bit wrap did not reload");
  flag_sticky_a: assert property (
    (ctrl_reg[ARC_CTRL_HOF] && !ctrl_wr) |=> ctrl_reg[ARC_CTRL_HOF])
    else $error("high flag dropped without a write");
  low_free_a: assert property (
    (CE && split_m && !run_m && tick_lo && cntl_reg != ARC_BYTE_MAX && !cnt_wr)
    |=> (cntl_reg == $past(cntl_reg) + ARC_BYTE_ONE) && $stable(cnth_reg))
    else $error("split low byte not free running");
  stopped_hold_a: assert property (
    (!split_m && !run_m && !cnt_wr) |=> $stable({cnth_reg, cntl_reg}))
    else $error("stopped counter moved");
  capture_copy_a: assert property (
    (CE && cap_evt) |=> ({rlh_reg, rll_reg} == $past({cnth_reg, cntl_reg}))
    && ctrl_reg[ARC_CTRL_HOF]) else $error("capture did not copy count");
  high_reload_a: assert property (
    (CE && split_m && run_m && tick_hi && cnth_reg == ARC_BYTE_MAX && !cnt_wr && !rl_wr
     && !cap_evt) |=> (cnth_reg == $past(rlh_reg)) && ctrl_reg[ARC_CTRL_HOF])
    else $error("split high byte did not reload");
  low_flag_a: assert property (
    (CE && lo_ovf) |=> ctrl_reg[ARC_CTRL_LOF] ##0 stat_reg[ARC_EV_LOF])
    else $error("low wrap did not set flag");
  irq_high_a: assert property (
    (eie_reg && ctrl_reg[ARC_CTRL_HOF]) |-> TIMER_IRQ) else $error("overflow without irq");
  irq_low_a: assert property (
    (eie_reg && ctrl_reg[ARC_CTRL_LBIE] && ctrl_reg[ARC_CTRL_LOF]) |-> TIMER_IRQ)
    else $error("low overflow without irq");
  irq_gate_a: assert property (
    (!eie_reg) |-> !TIMER_IRQ) else $error("irq while disabled");
  cap_trigger_a: assert property (
    (cap_m && !xclk_m[ARC_XCLK_CAPSEL] && cmp_rise) |-> cap_evt)
    else $error("comparator edge gave no capture");
  cap_bit_a: assert property (
    ctrl_wr |=> cap_m == $past(PWDATA[ARC_CTRL_CAPEN])) else $error("capture bit not written");
  sys_clk_a: assert property (
    (clock_control_reg_reg[ARC_CK_LOW]) |-> tick_lo) else $error("system_clock select not every cycle");

  // low byte reload, status recording and freeze checks; software only sees these
  // through reads several cycles later, so they are pinned here edge by edge
  low_reload_a: assert property (
    (CE && split_m && tick_lo && cntl_reg == ARC_BYTE_MAX && !cnt_wr)
    |=> (cntl_reg == $past(rll_reg)) && ctrl_reg[ARC_CTRL_LOF])
    else $error("split low byte did not reload");
  high_hold_a: assert property (
    (CE && split_m && !run_m && !cnt_wr) |=> $stable(cnth_reg))
    else $error("stopped split high byte moved");
  low_sticky_a: assert property (
    (ctrl_reg[ARC_CTRL_LOF] && !ctrl_wr) |=> ctrl_reg[ARC_CTRL_LOF])
    else $error("low flag dropped without a write");
  stat_high_a: assert property (
    (CE && hi_ovf) |=> stat_reg[ARC_EV_HOF]) else $error("high wrap not in status");
  cap_status_a: assert property (
    (CE && cap_evt) |=> stat_reg[ARC_EV_CAP]) else $error("capture not in status");
  div12_period_a: assert property (
    (CE && tick_sys12) |=> (div12_reg == '0)) else $error("divide by twelve lost its phase");
  ce_freeze_a: assert property (
    (!CE) |=> $stable({cnth_reg, cntl_reg}) && $stable(ctrl_reg) && $stable(stat_reg))
    else $error("state moved with clock enable low");
endmodule

/* arc_timer_tb.sv */
// arc_timer_tb: self-checking bench for the apb timer arc_timer.
// assumes a 10 MHz CLK and that the bench alone drives every input.
`timescale 1ns/10ps
module arc_timer_tb;
  import arc_pkg::*;
  logic CLK = 0, RESET_N = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic PREADY, PSLVERR, TIMER_IRQ, IRQ;
  logic COMP1 = 0, EXT_OSC = 0;
  int errors = 0, checks_done = 0;
  logic [31:0] rd; // word taken by the last read
  logic err; // error flag of the last transfer
  logic [7:0] lo, hi; // accepted count window
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} arc_row_s;
  // write, read back: upper data bits must be dropped
  arc_row_s rows [10] = '{'{ARC_ADDR_CTRL, 32'hFFFF_FF10, 32'h10},
    '{ARC_ADDR_CTRL, 32'h03, 32'h03}, '{ARC_ADDR_CTRL, 32'h00, 32'h00},
    '{ARC_ADDR_RLL, 32'hFFFF_FFA5, 32'hA5}, '{ARC_ADDR_RLH, 32'h5A, 32'h5A},
    '{ARC_ADDR_CNTL, 32'h3C, 32'h3C}, '{ARC_ADDR_CNTH, 32'hC3, 32'hC3},
    '{ARC_ADDR_CLOCK_CONTROL_REG, 32'hFF, 32'h03}, '{ARC_ADDR_EIE, 32'hFF, 32'h80},
    '{ARC_ADDR_MASK, 32'hFF, 32'h07}};

  // free-running 100 ns clock
  always #50 CLK = ~CLK;

  arc_timer uut (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .COMP1(COMP1), .EXT_OSC(EXT_OSC), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));

  // single compare point, counts every check
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task chkb(input string name, input logic seen, input logic exp);
    chk(name, {31'h0, seen}, {31'h0, exp});
  endtask

  // one apb transfer; waits for pready as long as it takes, the watchdog ends a hang
  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= is_wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    // let that edge's updates land before outputs are looked at
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task waitc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    waitc(20000);
    errors++;
    give_verdict;
  end

  initial begin
    waitc(12);
    RESET_N <= 1;
    // every register starts at zero
    for (int i = 0; i < 9; i++) begin
      rdr(8'(4 * i));
      chk("reset value", rd, ARC_RDATA_RST);
    end
    rdr(8'h24);
    chkb("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    // ordinary register cases from the table
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      chk("read back", rd, rows[i].e);
    end
    // 16-bit: hold while stopped, then wrap and reload
    wr(ARC_ADDR_RLL, 32'h00);
    wr(ARC_ADDR_RLH, 32'h12);
    wr(ARC_ADDR_CNTL, 32'hF0);
    wr(ARC_ADDR_CNTH, 32'hFF);
    waitc(30);
    rdr(ARC_ADDR_CNTH);
    chk("held count", rd, 32'hFF);
    wr(ARC_ADDR_CTRL, 32'h04);
    waitc(40);
    rdr(ARC_ADDR_CNTH);
    chk("reloaded high", rd, 32'h12);
    rdr(ARC_ADDR_CTRL);
    chk("wrap flags", rd, 32'hC4);
    chkb("timer irq", TIMER_IRQ, 1'b1);
    waitc(20);
    rdr(ARC_ADDR_CTRL);
    chk("flags stay", rd, 32'hC4);
    // status interrupt: raised, masked, cleared by read
    chkb("irq raised", IRQ, 1'b1);
    wr(ARC_ADDR_MASK, 32'h0);
    chkb("irq masked", IRQ, 1'b0);
    wr(ARC_ADDR_MASK, 32'h7);
    rdr(ARC_ADDR_STAT);
    chk("status", rd, 32'h03);
    chkb("irq cleared", IRQ, 1'b0);
    wr(ARC_ADDR_CTRL, 32'h00);
    chkb("timer irq clear", TIMER_IRQ, 1'b0);
    // low-byte wrap only interrupts with its own enable
    wr(ARC_ADDR_CNTL, 32'hF0);
    wr(ARC_ADDR_CNTH, 32'h00);
    wr(ARC_ADDR_CTRL, 32'h04);
    waitc(40);
    rdr(ARC_ADDR_CTRL);
    chk("low flag only", rd, 32'h44);
    chkb("no low irq", TIMER_IRQ, 1'b0);
    wr(ARC_ADDR_CTRL, 32'h64);
    chkb("low irq", TIMER_IRQ, 1'b1);
    wr(ARC_ADDR_CTRL, 32'h00);
    // split: low runs free, high gated by run
    wr(ARC_ADDR_RLL, 32'h80);
    wr(ARC_ADDR_CNTL, 32'hF0);
    wr(ARC_ADDR_CNTH, 32'h50);
    wr(ARC_ADDR_CTRL, 32'h08);
    waitc(40);
    rdr(ARC_ADDR_CNTH);
    chk("high gated", rd, 32'h50);
    rdr(ARC_ADDR_CNTL);
    chk("low reload", rd & 32'hE0, 32'h80);
    rdr(ARC_ADDR_CTRL);
    chk("split low flag", rd, 32'h48);
    chkb("split no irq", TIMER_IRQ, 1'b0);
    wr(ARC_ADDR_CTRL, 32'h68);
    chkb("split low irq", TIMER_IRQ, 1'b1);
    wr(ARC_ADDR_RLH, 32'hA0);
    wr(ARC_ADDR_CNTH, 32'hFC);
    wr(ARC_ADDR_CTRL, 32'h0C);
    waitc(10);
    rdr(ARC_ADDR_CNTH);
    chk("high reload", rd & 32'hF0, 32'hA0);
    rdr(ARC_ADDR_CTRL);
    chk("high flag", rd & 32'h80, 32'h80);
    chkb("split high irq", TIMER_IRQ, 1'b1);
    wr(ARC_ADDR_CTRL, 32'h00);
    // each external select code, 16 oscillator and 4 comparator rises;
    // both pins end low so no stray edge leaks into the next pass
    wr(ARC_ADDR_CLOCK_CONTROL_REG, 32'h0);
    for (int x = 0; x < 4; x++) begin
      wr(ARC_ADDR_CNTL, 32'h0);
      wr(ARC_ADDR_CNTH, 32'h0);
      wr(ARC_ADDR_CTRL, 32'h04 | x);
      for (int i = 0; i < 100; i++) begin
        @(posedge CLK);
        EXT_OSC <= (i % 6 >= 3) && (i < 96);
        COMP1 <= (i % 24 >= 1) && (i % 24 < 5) && (i < 96);
      end
      wr(ARC_ADDR_CTRL, 32'h00);
      rdr(ARC_ADDR_CNTL);
      // prescaler phase is free, so /12 gets a one-count window
      lo = (x == 1) ? 8'h02 : (x == 3) ? 8'h04 : 8'h08;
      hi = (x == 1) ? 8'h02 : (x == 3) ? 8'h04 : 8'h09;
      chkb("source count", rd[7:0] >= lo && rd[7:0] <= hi, 1'b1);
    end
    // capture on comparator rise; split kept low while capturing
    wr(ARC_ADDR_CLOCK_CONTROL_REG, 32'h1);
    wr(ARC_ADDR_CNTL, 32'h0);
    wr(ARC_ADDR_CNTH, 32'h0);
    rdr(ARC_ADDR_STAT);
    wr(ARC_ADDR_CTRL, 32'h14);
    waitc(5);
    COMP1 <= 1;
    waitc(3);
    COMP1 <= 0;
    waitc(6);
    rdr(ARC_ADDR_CTRL);
    chk("capture flag", rd & 32'h80, 32'h80);
    chkb("capture irq", TIMER_IRQ, 1'b1);
    rdr(ARC_ADDR_RLH);
    chk("captured high", rd, 32'h0);
    rdr(ARC_ADDR_RLL);
    chkb("captured low", rd != 32'h0, 1'b1);
    lo = rd[7:0];
    rdr(ARC_ADDR_STAT);
    chk("capture status", rd & 32'h4, 32'h4);
    // second rise 22 cycles after the first: the captures differ by 22 counts
    @(posedge CLK);
    COMP1 <= 1;
    waitc(3);
    COMP1 <= 0;
    waitc(6);
    rdr(ARC_ADDR_RLL);
    chk("capture spacing", {24'h00_0000, rd[7:0] - lo}, 32'h0000_0016);
    // oscillator trigger: seven rises give nothing, the eighth captures
    wr(ARC_ADDR_CTRL, 32'h16);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      EXT_OSC <= 1;
      waitc(2);
      EXT_OSC <= 0;
      waitc(8);
      rdr(ARC_ADDR_CTRL);
      chk("ext capture", rd & 32'h80, (i == 7) ? 32'h80 : 32'h0);
    end
    // reset in mid-run while the timer still counts
    @(posedge CLK);
    RESET_N <= 0;
    waitc(2);
    RESET_N <= 1;
    rdr(ARC_ADDR_CTRL);
    chk("ctrl after reset", rd, ARC_RDATA_RST);
    rdr(ARC_ADDR_CNTL);
    chk("count after reset", rd, ARC_RDATA_RST);
    chkb("irq after reset", TIMER_IRQ, 1'b0);
    // clock enable low stalls the bus
    @(posedge CLK);
    CE <= 0;
    @(posedge CLK);
    #1;
    chkb("stalled ready", PREADY, 1'b0);
    @(posedge CLK);
    CE <= 1;
    give_verdict;
  end
endmodule
